// ===== logic/can_xcvr_map.svh
// Summary of operation
// - Early dominant ignored until transmit returns recessive
// - Receive output follows differential receiver bus state in Normal and Receive Only
// - Receive-only disables driver; chip Normal or Stop
// - Wake-capable by software; forced in Fail-Safe
// - After bus wake, receive low until mode changes or detection rearms
// - Wake pattern: dominant, recessive, dominant within limits
// - Mode field still reads wake-capable after wake
// - Leaving and re-entering wake-capable rearms detection
// - Entering Stop, Sleep or Fail-Safe rearms detection
// - Stop/Normal wake: interrupt low, flag, receive low
// - Stop wake enables watchdog when configured
// - Sleep wake: Restart then Normal, no interrupt
// - Fail-Safe/Restart wake: Restart, interrupt high
// - Termination selected from transceiver mode
// - Ground termination only after silence interval
// - Transmit dominant timeout forces bus recessive
// - Timeout sets failure, mode kept, auto recovery
// - Long bus dominant sets failure, config kept
// - Clamp filter longer than transmit timeout
// - Supply undervoltage flags and disables transmitter
// - Undervoltage monitored only when upper mode bit set
// - Off after reset; bus wake ignored there
// - Normal mode allowed only in chip Normal
`ifndef CAN_XCVR_MAP_SVH
`define CAN_XCVR_MAP_SVH

`define CTRL_OFS 8'h00
`define CHIP_OFS 8'h04
`define STAT_OFS 8'h08

`define MODE_OFF 2'h0
`define MODE_WAKE 2'h1
`define MODE_RXO 2'h2
`define MODE_NORM 2'h3
`define CTRL_WDBW_BIT 2
`define CTRL_WDEN_BIT 3
`define STAT_WAKE_BIT 0
`define STAT_FAIL_BIT 1
`define STAT_UV_BIT 2
`define CHIP_MAX 3'h4

`define CLK_PERIOD_NS 5
`define EN_TIME_NS 5000
`define WAKE_MIN_NS 500
`define WAKE_MAX_NS 1800
`define RESTART_NS 1000
`define TXTO_NS 4500000
`define CLAMP_NS 5000000
`define SILENCE_NS 1000000
`define EN_CYC ((`EN_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WAKE_MIN_CYC ((`WAKE_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WAKE_MAX_CYC (`WAKE_MAX_NS / `CLK_PERIOD_NS)
`define RESTART_CYC ((`RESTART_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TXTO_CYC ((`TXTO_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CLAMP_CYC ((`CLAMP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SILENCE_CYC ((`SILENCE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ===== logic/can_xcvr_pkg.sv
package can_xcvr_pkg;
  typedef enum logic [2:0] {
    CHIP_NORMAL, CHIP_STOP, CHIP_SLEEP, CHIP_RESTART, CHIP_FAILSAFE
  } chip_mode_e;
  typedef enum logic [1:0] {
    TERM_FLOAT, TERM_HALF, TERM_GND, TERM_2V5
  } term_e;
  typedef enum logic [1:0] {
    WK_IDLE, WK_DOM1, WK_REC1, WK_DOM2
  } wake_state_e;
endpackage

// ===== logic/can_xcvr_ctrl.sv
`timescale 1ns/1ps
`include "can_xcvr_map.svh"
module can_xcvr_ctrl #(
  parameter int unsigned TXTO_CYC = `TXTO_CYC,
  parameter int unsigned CLAMP_CYC = `CLAMP_CYC,
  parameter int unsigned SILENCE_CYC = `SILENCE_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic tx_data_in_i,
  input wire logic bus_rx_i,
  input wire logic xcvr_supply_uv_i,
  output logic tx_dom_o,
  output logic rx_data_out_o,
  output logic irq_out_n_o,
  output can_xcvr_pkg::term_e term_sel_o,
  output can_xcvr_pkg::chip_mode_e chip_mode_o,
  output logic watchdog_en_o
);

  logic [1:0] mode;
  logic wd_bus_wake, wd_en, wake_flag, can_fail, uv_flag, irq_pend, woken;
  can_xcvr_pkg::chip_mode_e chip, chip_prev;
  can_xcvr_pkg::wake_state_e wk_state;
  logic [15:0] wk_cnt, en_cnt, rs_cnt;
  logic [31:0] txd_cnt, clamp_cnt, sil_cnt;
  logic wake_evt, wk_active, rearm, tx_ready, tx_hold, tx_to, to_hit;
  logic clamp_hit, sil_done, bus_dom, next_tx_dom;
  logic req, wr, wr_ctrl, wr_chip, wr_stat;

  // Bus request decode; only byte lane 0 carries any field
  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr = req & wb_we_i & wb_sel_i[0];
  assign wr_ctrl = wr & (wb_adr_i == `CTRL_OFS);
  assign wr_chip = wr & (wb_adr_i == `CHIP_OFS);
  assign wr_stat = wr & (wb_adr_i == `STAT_OFS);
  assign bus_dom = ~bus_rx_i;

  // One-cycle answer; unmapped addresses ack with zero data
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= 32'h0;
      if (req && !wb_we_i) begin
        unique case (wb_adr_i)
          `CTRL_OFS: wb_dat_o <= {28'h0, wd_en, wd_bus_wake, mode};
          `CHIP_OFS: wb_dat_o <= {29'h0, chip};
          `STAT_OFS: wb_dat_o <= {27'h0, woken, tx_to, uv_flag,
                                  can_fail, wake_flag};
          default: wb_dat_o <= 32'h0;
        endcase
      end
    end
  end

  // Transceiver mode; illegal requests for the chip mode are dropped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode <= `MODE_OFF;
      wd_bus_wake <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        wd_bus_wake <= wb_dat_i[`CTRL_WDBW_BIT];
        unique case (wb_dat_i[1:0])
          `MODE_OFF: mode <= `MODE_OFF;
          `MODE_WAKE: mode <= `MODE_WAKE;
          `MODE_RXO: begin
            if (chip == can_xcvr_pkg::CHIP_NORMAL ||
                chip == can_xcvr_pkg::CHIP_STOP) begin
              mode <= `MODE_RXO;
            end
          end
          `MODE_NORM: begin
            if (chip == can_xcvr_pkg::CHIP_NORMAL) begin
              mode <= `MODE_NORM;
            end
          end
        endcase
      end
      // Fail-Safe overrides anything software asks for
      if (chip == can_xcvr_pkg::CHIP_FAILSAFE) begin
        mode <= `MODE_WAKE;
      end
    end
  end

  // Chip mode: software sets it, a bus wake or restart dwell moves it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chip <= can_xcvr_pkg::CHIP_NORMAL;
      chip_prev <= can_xcvr_pkg::CHIP_NORMAL;
      rs_cnt <= 16'h0;
    end else begin
      chip_prev <= chip;
      if (chip == can_xcvr_pkg::CHIP_RESTART) begin
        rs_cnt <= rs_cnt + 16'h1;
      end else begin
        rs_cnt <= 16'h0;
      end
      if (wr_chip && wb_dat_i[2:0] <= `CHIP_MAX) begin
        chip <= can_xcvr_pkg::chip_mode_e'(wb_dat_i[2:0]);
      end
      if (chip == can_xcvr_pkg::CHIP_RESTART &&
          rs_cnt == 16'(`RESTART_CYC - 1)) begin
        chip <= can_xcvr_pkg::CHIP_NORMAL;
      end
      // Hardware event wins over a software write in the same cycle
      if (wake_evt && (chip == can_xcvr_pkg::CHIP_SLEEP ||
          chip == can_xcvr_pkg::CHIP_RESTART ||
          chip == can_xcvr_pkg::CHIP_FAILSAFE)) begin
        chip <= can_xcvr_pkg::CHIP_RESTART;
      end
    end
  end

  // Rearm when the chip newly enters a low-power or safe mode
  assign rearm = (chip != chip_prev) &&
                 (chip == can_xcvr_pkg::CHIP_STOP ||
                  chip == can_xcvr_pkg::CHIP_SLEEP ||
                  chip == can_xcvr_pkg::CHIP_FAILSAFE);

  // Off mode and a used-up detector both ignore the bus
  assign wk_active = (mode == `MODE_WAKE) && !woken;

  // Pattern detector counts each bus phase in clock cycles
  always_ff @(posedge clk_i) begin
    if (rst_i || !wk_active) begin
      wk_state <= can_xcvr_pkg::WK_IDLE;
      wk_cnt <= 16'h0;
    end else begin
      if (wk_cnt != 16'hffff) begin
        wk_cnt <= wk_cnt + 16'h1;
      end
      unique case (wk_state)
        can_xcvr_pkg::WK_IDLE: begin
          wk_cnt <= 16'h1;
          if (bus_dom) begin
            wk_state <= can_xcvr_pkg::WK_DOM1;
          end
        end
        can_xcvr_pkg::WK_DOM1, can_xcvr_pkg::WK_DOM2: begin
          if (wk_cnt >= 16'(`WAKE_MAX_CYC)) begin
            wk_state <= can_xcvr_pkg::WK_IDLE;
          end else if (!bus_dom) begin
            wk_cnt <= 16'h1;
            if (wk_cnt < 16'(`WAKE_MIN_CYC) ||
                wk_state == can_xcvr_pkg::WK_DOM2) begin
              wk_state <= can_xcvr_pkg::WK_IDLE;
            end else begin
              wk_state <= can_xcvr_pkg::WK_REC1;
            end
          end
        end
        can_xcvr_pkg::WK_REC1: begin
          if (wk_cnt >= 16'(`WAKE_MAX_CYC)) begin
            wk_state <= can_xcvr_pkg::WK_IDLE;
          end else if (bus_dom) begin
            wk_cnt <= 16'h1;
            if (wk_cnt > 16'(`WAKE_MIN_CYC)) begin
              wk_state <= can_xcvr_pkg::WK_DOM2;
            end else begin
              wk_state <= can_xcvr_pkg::WK_IDLE;
            end
          end
        end
      endcase
    end
  end

  // Second dominant phase ends in range: pattern complete
  assign wake_evt = wk_active && wk_state == can_xcvr_pkg::WK_DOM2 &&
                    !bus_dom && wk_cnt >= 16'(`WAKE_MIN_CYC) &&
                    wk_cnt < 16'(`WAKE_MAX_CYC);

  // Woken latch; mode field itself is left at wake-capable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      woken <= 1'b0;
    end else if (wake_evt) begin
      woken <= 1'b1;
    end else if (mode != `MODE_WAKE || rearm) begin
      woken <= 1'b0;
    end
  end

  // Status flags: hardware set beats a write-one clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wake_flag <= 1'b0;
      irq_pend <= 1'b0;
      can_fail <= 1'b0;
      uv_flag <= 1'b0;
    end else begin
      if (wr_stat && wb_dat_i[`STAT_WAKE_BIT]) begin
        wake_flag <= 1'b0;
        irq_pend <= 1'b0;
      end
      if (wr_stat && wb_dat_i[`STAT_FAIL_BIT]) begin
        can_fail <= 1'b0;
      end
      if (wr_stat && wb_dat_i[`STAT_UV_BIT]) begin
        uv_flag <= 1'b0;
      end
      if (wake_evt) begin
        wake_flag <= 1'b1;
      end
      if (wake_evt && (chip == can_xcvr_pkg::CHIP_STOP ||
          chip == can_xcvr_pkg::CHIP_NORMAL)) begin
        irq_pend <= 1'b1;
      end
      if (to_hit || clamp_hit) begin
        can_fail <= 1'b1;
      end
      if (mode[1] && xcvr_supply_uv_i) begin
        uv_flag <= 1'b1;
      end
    end
  end

  // Watchdog enable, also switched on by a bus wake in Stop
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wd_en <= 1'b0;
    end else if (wake_evt && chip == can_xcvr_pkg::CHIP_STOP &&
                 !wd_en && wd_bus_wake) begin
      wd_en <= 1'b1;
    end else if (wr_ctrl) begin
      wd_en <= wb_dat_i[`CTRL_WDEN_BIT];
    end
  end

  // Enabling delay restarts each time Normal is entered
  always_ff @(posedge clk_i) begin
    if (rst_i || mode != `MODE_NORM) begin
      en_cnt <= 16'h0;
    end else if (!tx_ready) begin
      en_cnt <= en_cnt + 16'h1;
    end
  end
  assign tx_ready = en_cnt == 16'(`EN_CYC);

  // A dominant begun too early stays blocked until recessive
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_hold <= 1'b0;
    end else begin
      tx_hold <= ~tx_data_in_i & (tx_hold | ~tx_ready);
    end
  end

  // Transmit dominant timeout; cleared once the input goes recessive
  always_ff @(posedge clk_i) begin
    if (rst_i || mode != `MODE_NORM || tx_data_in_i) begin
      txd_cnt <= 32'h0;
    end else if (!tx_to) begin
      txd_cnt <= txd_cnt + 32'h1;
    end
  end
  assign tx_to = txd_cnt >= TXTO_CYC;
  assign to_hit = !tx_to && mode == `MODE_NORM && !tx_data_in_i &&
                  txd_cnt == TXTO_CYC - 1;

  // Bus clamp filter, watched in Normal and Receive Only
  always_ff @(posedge clk_i) begin
    if (rst_i || !mode[1] || !bus_dom) begin
      clamp_cnt <= 32'h0;
    end else if (clamp_cnt < CLAMP_CYC) begin
      clamp_cnt <= clamp_cnt + 32'h1;
    end
  end
  assign clamp_hit = mode[1] && bus_dom &&
                     clamp_cnt == CLAMP_CYC - 1;

  // Silence interval before ground termination in wake mode
  always_ff @(posedge clk_i) begin
    if (rst_i || mode != `MODE_WAKE) begin
      sil_cnt <= 32'h0;
    end else if (!sil_done) begin
      sil_cnt <= sil_cnt + 32'h1;
    end
  end
  assign sil_done = sil_cnt >= SILENCE_CYC;

  // Driver gate: delay, early block, timeout and supply all veto
  assign next_tx_dom = mode == `MODE_NORM && tx_ready && !tx_hold &&
                       !tx_to && !xcvr_supply_uv_i &&
                       !tx_data_in_i;

  // Registered pin outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_dom_o <= 1'b0;
      rx_data_out_o <= 1'b1;
      term_sel_o <= can_xcvr_pkg::TERM_FLOAT;
    end else begin
      tx_dom_o <= next_tx_dom;
      unique case (mode)
        `MODE_OFF: begin
          rx_data_out_o <= 1'b1;
          term_sel_o <= can_xcvr_pkg::TERM_FLOAT;
        end
        `MODE_WAKE: begin
          rx_data_out_o <= ~woken;
          if (woken) begin
            term_sel_o <= can_xcvr_pkg::TERM_2V5;
          end else if (sil_done) begin
            term_sel_o <= can_xcvr_pkg::TERM_GND;
          end else begin
            term_sel_o <= can_xcvr_pkg::TERM_FLOAT;
          end
        end
        `MODE_RXO: begin
          rx_data_out_o <= bus_rx_i;
          term_sel_o <= xcvr_supply_uv_i ? can_xcvr_pkg::TERM_2V5 :
                        can_xcvr_pkg::TERM_HALF;
        end
        `MODE_NORM: begin
          rx_data_out_o <= bus_rx_i;
          term_sel_o <= can_xcvr_pkg::TERM_HALF;
        end
      endcase
    end
  end

  assign irq_out_n_o = ~irq_pend;
  assign chip_mode_o = chip;
  assign watchdog_en_o = wd_en;

  // Checks
  a_early_tx_block: assert property (@(posedge clk_i) disable iff (rst_i)
    tx_dom_o |-> $past(tx_ready) && !$past(tx_hold))
    else $error("dominant driven before enable delay");
  a_rx_follow: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(mode[1]) |-> rx_data_out_o == $past(bus_rx_i))
    else $error("receive output not following bus");
  a_rxo_silent: assert property (@(posedge clk_i) disable iff (rst_i)
    mode == `MODE_RXO |=> !tx_dom_o)
    else $error("driver active in receive only");
  a_failsafe_wake: assert property (@(posedge clk_i) disable iff (rst_i)
    chip == can_xcvr_pkg::CHIP_FAILSAFE |=> mode == `MODE_WAKE)
    else $error("fail-safe did not force wake mode");
  a_woken_rx_low: assert property (@(posedge clk_i) disable iff (rst_i)
    wake_evt ##1 mode == `MODE_WAKE |=> !rx_data_out_o)
    else $error("receive not low after wake");
  a_mode_kept: assert property (@(posedge clk_i) disable iff (rst_i)
    wake_evt && !wr_ctrl |=> mode == `MODE_WAKE)
    else $error("mode changed by wake");
  a_rearm_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    rearm && !wake_evt |=> !woken)
    else $error("rearm did not clear wake latch");
  a_irq_stop: assert property (@(posedge clk_i) disable iff (rst_i)
    wake_evt && chip == can_xcvr_pkg::CHIP_STOP
    |=> !irq_out_n_o && wake_flag)
    else $error("no interrupt on stop wake");
  a_wd_auto: assert property (@(posedge clk_i) disable iff (rst_i)
    wake_evt && chip == can_xcvr_pkg::CHIP_STOP && wd_bus_wake
    |=> wd_en)
    else $error("watchdog not enabled by bus wake");
  a_sleep_restart: assert property (@(posedge clk_i) disable iff (rst_i)
    wake_evt && chip == can_xcvr_pkg::CHIP_SLEEP && !irq_pend
    |=> chip == can_xcvr_pkg::CHIP_RESTART && irq_out_n_o)
    else $error("sleep wake handled wrong");
  a_tx_timeout: assert property (@(posedge clk_i) disable iff (rst_i)
    to_hit |=> tx_to && can_fail ##1 !tx_dom_o)
    else $error("transmit timeout not enforced");
  a_clamp_fail: assert property (@(posedge clk_i) disable iff (rst_i)
    clamp_hit |=> can_fail && $stable(mode))
    else $error("clamp not flagged");
  a_filter_order: assert property (@(posedge clk_i)
    CLAMP_CYC > TXTO_CYC)
    else $error("clamp filter not above timeout");
  a_uv_block: assert property (@(posedge clk_i) disable iff (rst_i)
    mode[1] && xcvr_supply_uv_i |=> uv_flag && !tx_dom_o)
    else $error("undervoltage not handled");
  a_off_float: assert property (@(posedge clk_i) disable iff (rst_i)
    mode == `MODE_OFF |=> term_sel_o == can_xcvr_pkg::TERM_FLOAT)
    else $error("off mode not floating");

  c_wake_seen: cover property (@(posedge clk_i) disable iff (rst_i)
    wake_evt);
  c_tx_timeout: cover property (@(posedge clk_i) disable iff (rst_i)
    to_hit);
  c_clamp: cover property (@(posedge clk_i) disable iff (rst_i)
    clamp_hit);
  c_early_block: cover property (@(posedge clk_i) disable iff (rst_i)
    tx_hold && tx_ready);

endmodule

// ===== verification/can_ctrl_model.sv
`timescale 1ns/1ps
`include "can_xcvr_map.svh"
// Protocol controller stand-in: one dominant pulse of hold_i cycles
module can_ctrl_model #(
  parameter int unsigned EN_WAIT = `EN_CYC + 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic go_i,
  input wire logic now_i,
  input wire logic [15:0] hold_i,
  output logic tx_o,
  output logic busy_o
);
  logic [1:0] st;
  logic [15:0] cnt;

  // Recessive from time zero so the transceiver never sees an unknown
  initial begin
    tx_o = 1'b1;
    busy_o = 1'b0;
    st = 2'h0;
    cnt = 16'h0000;
  end

  // now_i skips the wait on purpose, for scenarios that send too early
  always @(posedge clk_i) begin
    if (rst_i) begin
      tx_o <= 1'b1;
      busy_o <= 1'b0;
      st <= 2'h0;
    end else begin
      case (st)
        2'h0: begin
          if (go_i) begin
            busy_o <= 1'b1;
            cnt <= now_i ? 16'h0000 : 16'(EN_WAIT);
            st <= 2'h1;
          end
        end
        2'h1: begin
          if (cnt == 16'h0000) begin
            tx_o <= 1'b0;
            cnt <= hold_i;
            st <= 2'h2;
          end else begin
            cnt <= cnt - 16'h0001;
          end
        end
        default: begin
          if (cnt <= 16'h0001) begin
            tx_o <= 1'b1;
            busy_o <= 1'b0;
            st <= 2'h0;
          end else begin
            cnt <= cnt - 16'h0001;
          end
        end
      endcase
    end
  end
endmodule

// ===== verification/tb_can_transceiver_mode_wake_control.sv
`timescale 1ns/1ps
module tb_can_transceiver_mode_wake_control;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] q;
  logic ack, tx, tx_dom, rxo, irq_n, wden, busy, b;
  logic bus_rx = 1'b1;
  logic uv = 1'b0;
  logic go = 1'b0;
  logic now = 1'b0;
  logic [15:0] hold = 16'h0000;
  can_xcvr_pkg::term_e term;
  can_xcvr_pkg::chip_mode_e chip;
  int errors = 0;
  int n_compared = 0;

  // Short counts keep the timeout and clamp scenarios quick
  can_xcvr_ctrl #(.TXTO_CYC(50), .CLAMP_CYC(80), .SILENCE_CYC(20)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .tx_data_in_i(tx),
    .bus_rx_i(bus_rx), .xcvr_supply_uv_i(uv), .tx_dom_o(tx_dom),
    .rx_data_out_o(rxo), .irq_out_n_o(irq_n), .term_sel_o(term),
    .chip_mode_o(chip), .watchdog_en_o(wden));

  can_ctrl_model ctrl (.clk_i(clk_i), .rst_i(rst_i), .go_i(go),
    .now_i(now), .hold_i(hold), .tx_o(tx), .busy_o(busy));

  // 200 MHz clock
  always #2.5 clk_i = ~clk_i;

  task automatic end_sim;
    $display("Compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // Classic cycle: hold everything until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hf;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 40);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (n >= 40) begin
      errors++;
      $display("Error at %0t: no bus answer", $time);
    end
  endtask

  // Dominant, recessive, dominant on the bus, then recessive
  task automatic pat(input int d1, input int r, input int d2);
    bus_rx <= 1'b0;
    tick(d1);
    bus_rx <= 1'b1;
    tick(r);
    bus_rx <= 1'b0;
    tick(d2);
    bus_rx <= 1'b1;
    tick(4);
  endtask

  // Random legal pattern: every phase between the two limits
  task automatic rpat;
    pat(110 + $urandom % 230, 110 + $urandom % 230, 110 + $urandom % 230);
  endtask

  // Controller pulse; driver state looked at k cycles into it
  task automatic send(input logic nw, input int h, input int k,
                      input logic e);
    int n;
    go <= 1'b1;
    now <= nw;
    hold <= 16'(h);
    @(posedge clk_i);
    go <= 1'b0;
    n = 0;
    while (tx !== 1'b0 && n < 1200) begin
      @(posedge clk_i);
      n++;
    end
    tick(k);
    chk(tx_dom, e);
    while (busy !== 1'b0 && n < 2400) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 2400) begin
      errors++;
      $display("Error at %0t: controller hung", $time);
    end
  endtask

  // Hang guard, well above the expected run length
  initial begin
    #100000;
    errors++;
    end_sim();
  end

  initial begin
    void'($urandom(1618));
    tick(12);
    rst_i <= 1'b0;
    tick(2);
    chk(rxo, 1'b1);
    chk(irq_n, 1'b1);
    chk(term, can_xcvr_pkg::TERM_FLOAT);
    chk(tx_dom, 1'b0);
    wb(1'b0, 8'h00, 32'h0);
    chk(q, 32'h0);
    wb(1'b1, 8'h0c, 32'hffffffff);
    wb(1'b0, 8'h0c, 32'h0);
    chk(q, 32'h0);
    rpat();
    chk(rxo, 1'b1);
    wb(1'b0, 8'h08, 32'h0);
    chk(q, 32'h0);
    // Normal mode: enabling delay, reception, timeout, clamping
    wb(1'b1, 8'h00, 32'h3);
    tick(2);
    chk(term, can_xcvr_pkg::TERM_HALF);
    send(1'b1, 40, 30, 1'b0);
    send(1'b0, 30, 20, 1'b1);
    repeat (24) begin
      b = 1'($urandom);
      bus_rx <= b;
      tick(2);
      chk(rxo, b);
    end
    bus_rx <= 1'b1;
    send(1'b1, 70, 60, 1'b0);
    wb(1'b0, 8'h08, 32'h0);
    chk(q, 32'h2);
    wb(1'b0, 8'h00, 32'h0);
    chk(q, 32'h3);
    send(1'b1, 30, 20, 1'b1);
    wb(1'b1, 8'h08, 32'h2);
    bus_rx <= 1'b0;
    tick(70);
    bus_rx <= 1'b1;
    wb(1'b0, 8'h08, 32'h0);
    chk(q, 32'h0);
    bus_rx <= 1'b0;
    tick(90);
    bus_rx <= 1'b1;
    wb(1'b0, 8'h08, 32'h0);
    chk(q, 32'h2);
    wb(1'b0, 8'h00, 32'h0);
    chk(q, 32'h3);
    wb(1'b1, 8'h08, 32'h2);
    // Supply undervoltage in Normal, Receive Only and Off
    uv <= 1'b1;
    tick(3);
    send(1'b1, 30, 20, 1'b0);
    wb(1'b0, 8'h08, 32'h0);
    chk(q, 32'h4);
    uv <= 1'b0;
    tick(3);
    send(1'b1, 30, 20, 1'b1);
    wb(1'b1, 8'h00, 32'h2);
    uv <= 1'b1;
    tick(3);
    chk(term, can_xcvr_pkg::TERM_2V5);
    send(1'b1, 30, 20, 1'b0);
    uv <= 1'b0;
    tick(3);
    chk(term, can_xcvr_pkg::TERM_HALF);
    wb(1'b1, 8'h00, 32'h0);
    wb(1'b1, 8'h08, 32'h4);
    uv <= 1'b1;
    tick(3);
    wb(1'b0, 8'h08, 32'h0);
    chk(q, 32'h0);
    uv <= 1'b0;
    // Mode legality per chip mode
    wb(1'b1, 8'h04, 32'h1);
    wb(1'b1, 8'h00, 32'h3);
    wb(1'b0, 8'h00, 32'h0);
    chk(q, 32'h0);
    wb(1'b1, 8'h00, 32'h2);
    wb(1'b0, 8'h00, 32'h0);
    chk(q, 32'h2);
    wb(1'b1, 8'h04, 32'h2);
    wb(1'b1, 8'h00, 32'h0);
    wb(1'b1, 8'h00, 32'h2);
    wb(1'b0, 8'h00, 32'h0);
    chk(q, 32'h0);
    // Wake in Stop, with watchdog on bus wake
    wb(1'b1, 8'h04, 32'h1);
    wb(1'b1, 8'h00, 32'h5);
    chk(term, can_xcvr_pkg::TERM_FLOAT);
    tick(25);
    chk(term, can_xcvr_pkg::TERM_GND);
    pat(50, 150, 150);
    tick(400);
    chk(rxo, 1'b1);
    rpat();
    chk(rxo, 1'b0);
    chk(irq_n, 1'b0);
    chk(term, can_xcvr_pkg::TERM_2V5);
    chk(chip, can_xcvr_pkg::CHIP_STOP);
    chk(wden, 1'b1);
    wb(1'b0, 8'h00, 32'h0);
    chk(q, 32'hd);
    wb(1'b1, 8'h08, 32'h1);
    tick(1);
    chk(irq_n, 1'b1);
    rpat();
    wb(1'b0, 8'h08, 32'h0);
    chk(q, 32'h10);
    wb(1'b1, 8'h00, 32'h4);
    tick(2);
    chk(rxo, 1'b1);
    wb(1'b1, 8'h00, 32'h5);
    tick(25);
    rpat();
    wb(1'b0, 8'h08, 32'h0);
    chk(q, 32'h11);
    wb(1'b1, 8'h08, 32'h1);
    // Sleep entry rearms, wake goes through Restart
    wb(1'b1, 8'h04, 32'h2);
    tick(2);
    chk(rxo, 1'b1);
    rpat();
    chk(chip, can_xcvr_pkg::CHIP_RESTART);
    chk(irq_n, 1'b1);
    chk(rxo, 1'b0);
    wb(1'b0, 8'h08, 32'h0);
    chk(q[0], 1'b1);
    tick(210);
    chk(chip, can_xcvr_pkg::CHIP_NORMAL);
    // Fail-Safe forces wake-capable
    wb(1'b1, 8'h00, 32'h0);
    wb(1'b1, 8'h04, 32'h4);
    tick(2);
    wb(1'b0, 8'h00, 32'h0);
    chk(q[1:0], 2'h1);
    tick(25);
    rpat();
    chk(chip, can_xcvr_pkg::CHIP_RESTART);
    chk(irq_n, 1'b1);
    chk(rxo, 1'b0);
    end_sim();
  end
endmodule
